// ==== supply_guard.sv ====
// supply-voltage supervisor control: reset hold, warning, cause status
`timescale 1ns/1ps
module supply_guard #(
  parameter bit WARN_IRQ_VARIANT = 1'b1
) (
  // clock and power-on reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst_b,
  // analog comparator outputs and stop state
  input  wire supply_guard_pkg::cmp_s            cmp_raw,
  input  wire logic                              stop_mode,
  // register port
  input  wire logic [supply_guard_pkg::ADDR_W-1:0] addr,
  input  wire logic [supply_guard_pkg::DATA_W-1:0] wr_data,
  input  wire logic                              wr_stb,
  input  wire logic                              rd_stb,
  output      logic [supply_guard_pkg::DATA_W-1:0] rd_data,
  // to the processor core
  output      logic                              sys_rst_req,
  output      logic                              irq_req
);

  supply_guard_pkg::cmp_s     cmp_s_q;
  logic                       det_hit;
  logic                       warn_hit;
  logic                       det_active;

  supply_guard_pkg::sup_state_e state_reg;
  supply_guard_pkg::sup_state_e state_next;
  logic [7:0]                 ctrl1_reg;
  logic [7:0]                 ctrl1_next;
  logic [7:0]                 ctrl2_reg;
  logic [7:0]                 ctrl2_next;
  logic                       warn_flag_reg;
  logic                       warn_flag_next;
  logic [7:0]                 cause_reg;
  logic [7:0]                 cause_next;
  logic [7:0]                 rd_data_reg;
  logic [7:0]                 rd_data_next;
  logic                       sys_rst_reg;
  logic                       sys_rst_next;
  logic                       irq_reg;
  logic                       irq_next;

  // comparators are asynchronous to the bus clock
  cmp_sync u_sync (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .cmp_raw      (cmp_raw),
    .cmp_sync_out (cmp_s_q)
  );

  trip_select #(
    .WARN_IRQ_VARIANT (WARN_IRQ_VARIANT)
  ) u_trip (
    .cmp_in       (cmp_s_q),
    .det_lvl_sel  (ctrl2_reg[supply_guard_pkg::C2_DET_LVL_SEL]),
    .warn_lvl_sel (ctrl2_reg[supply_guard_pkg::C2_WARN_LVL_SEL]),
    .det_hit      (det_hit),
    .warn_hit     (warn_hit)
  );

  // detection runs when enabled, and in stop only if kept alive there
  assign det_active = ctrl1_reg[supply_guard_pkg::C1_DET_EN] &&
                      (!stop_mode ||
                       ctrl1_reg[supply_guard_pkg::C1_DET_STOP_EN]);

  // reset sequencing and cause recording
  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    case (state_reg)
      supply_guard_pkg::ST_RUN: begin
        if (cmp_s_q.por_below) begin
          state_next = supply_guard_pkg::ST_POR_HOLD;
          cause_next = supply_guard_pkg::CAUSE_POWER_ON;
        end else if (det_active && det_hit &&
                     ctrl1_reg[supply_guard_pkg::C1_DET_RST_EN]) begin
          state_next = supply_guard_pkg::ST_DET_HOLD;
          cause_next = supply_guard_pkg::CAUSE_UNDERVOLT;
        end
      end
      supply_guard_pkg::ST_POR_HOLD: begin
        // release needs the supply above the low detect level
        if (!cmp_s_q.por_below &&
            !cmp_s_q.det_below[supply_guard_pkg::DET_LOW]) begin
          state_next = supply_guard_pkg::ST_RUN;
        end
      end
      supply_guard_pkg::ST_DET_HOLD: begin
        if (cmp_s_q.por_below) begin
          state_next = supply_guard_pkg::ST_POR_HOLD;
          cause_next = supply_guard_pkg::CAUSE_POWER_ON;
        end else if (!det_hit) begin
          state_next = supply_guard_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = supply_guard_pkg::ST_POR_HOLD;
      end
    endcase
    sys_rst_next = (state_next != supply_guard_pkg::ST_RUN);
  end

  // control registers, warning flag and read port
  always_comb begin
    ctrl1_next     = ctrl1_reg;
    ctrl2_next     = ctrl2_reg;
    warn_flag_next = warn_flag_reg;
    rd_data_next   = supply_guard_pkg::READ_ZERO;
    if (state_reg != supply_guard_pkg::ST_RUN) begin
      // a held system reset returns the controls to their defaults, except the detect level select during the detect hold
      ctrl1_next     = supply_guard_pkg::PWR_CTRL_1_RST;
      ctrl2_next     = supply_guard_pkg::PWR_CTRL_2_RST;
      warn_flag_next = 1'b0;
      if (state_reg == supply_guard_pkg::ST_DET_HOLD) begin
        // the detect hold must release at the level that tripped it
        ctrl2_next[supply_guard_pkg::C2_DET_LVL_SEL] =
          ctrl2_reg[supply_guard_pkg::C2_DET_LVL_SEL];
      end
    end else begin
      if (wr_stb) begin
        if (addr == supply_guard_pkg::OFS_PWR_CTRL_1) begin
          ctrl1_next = wr_data & supply_guard_pkg::PWR_CTRL_1_WMSK;
          if (wr_data[supply_guard_pkg::C1_WARN_ACK]) begin
            warn_flag_next = 1'b0;
          end
        end else if (addr == supply_guard_pkg::OFS_PWR_CTRL_2) begin
          ctrl2_next = wr_data & supply_guard_pkg::PWR_CTRL_2_WMSK;
        end
      end
      // set after clear, so a coincident event is not lost
      if (warn_hit) begin
        warn_flag_next = 1'b1;
      end
    end
    if (rd_stb) begin
      if (addr == supply_guard_pkg::OFS_PWR_CTRL_1) begin
        rd_data_next = ctrl1_reg;
        rd_data_next[supply_guard_pkg::C1_WARN_FLAG] = warn_flag_reg;
        rd_data_next[supply_guard_pkg::C1_WARN_ACK]  = 1'b0;
      end else if (addr == supply_guard_pkg::OFS_PWR_CTRL_2) begin
        rd_data_next = ctrl2_reg;
      end else if (addr == supply_guard_pkg::OFS_RESET_CAUSE) begin
        rd_data_next = cause_reg;
      end
    end
  end

  // interrupt request is a level, re-requested while the condition holds
  always_comb begin
    irq_next = 1'b0;
    if (state_next == supply_guard_pkg::ST_RUN) begin
      if (WARN_IRQ_VARIANT) begin
        // detect levels only ever reset in this variant
        irq_next = ctrl1_reg[supply_guard_pkg::C1_WARN_IRQ_EN] &&
                   warn_hit;
      end else begin
        irq_next = det_active && det_hit &&
                   ctrl1_reg[supply_guard_pkg::C1_DET_IRQ_EN] &&
                   !ctrl1_reg[supply_guard_pkg::C1_DET_RST_EN];
      end
    end
  end

  // all state registers; power-on reset starts in the held state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= supply_guard_pkg::ST_POR_HOLD;
      ctrl1_reg     <= supply_guard_pkg::PWR_CTRL_1_RST;
      ctrl2_reg     <= supply_guard_pkg::PWR_CTRL_2_RST;
      warn_flag_reg <= 1'b0;
      cause_reg     <= supply_guard_pkg::CAUSE_POWER_ON;
      rd_data_reg   <= supply_guard_pkg::READ_ZERO;
      sys_rst_reg   <= 1'b1;
      irq_reg       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ctrl1_reg     <= ctrl1_next;
      ctrl2_reg     <= ctrl2_next;
      warn_flag_reg <= warn_flag_next;
      cause_reg     <= cause_next;
      rd_data_reg   <= rd_data_next;
      sys_rst_reg   <= sys_rst_next;
      irq_reg       <= irq_next;
    end
  end

  assign rd_data     = rd_data_reg;
  assign sys_rst_req = sys_rst_reg;
  assign irq_req     = irq_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // checks beside the logic they guard
  AST_DET_EN_AFTER_POR: assert property (
    $rose(rst_b) |-> ctrl1_reg[supply_guard_pkg::C1_DET_EN]
  ) else $error("detect enable not set after power-on reset");

  AST_POR_ASSERTS_RESET: assert property (
    cmp_s_q.por_below |=> sys_rst_req
  ) else $error("power-on comparator did not assert reset");

  AST_POR_HOLD_LOW_DET: assert property (
    (state_reg == supply_guard_pkg::ST_POR_HOLD) &&
    cmp_s_q.det_below[supply_guard_pkg::DET_LOW] |=> sys_rst_req
  ) else $error("reset released below low detect level");

  AST_POR_CAUSE_BITS: assert property (
    (state_reg == supply_guard_pkg::ST_RUN) && cmp_s_q.por_below |=>
      cause_reg[supply_guard_pkg::RC_POWER_ON] &&
      cause_reg[supply_guard_pkg::RC_UNDERVOLT]
  ) else $error("power-on cause bits not set");

  AST_STOP_NO_DETECT: assert property (
    (state_reg == supply_guard_pkg::ST_RUN) && stop_mode && det_hit &&
    !ctrl1_reg[supply_guard_pkg::C1_DET_STOP_EN] && !cmp_s_q.por_below
      |=> !sys_rst_req
  ) else $error("detect reset taken in stop without stop enable");

  AST_DET_RESET_CAUSE: assert property (
    (state_reg == supply_guard_pkg::ST_RUN) && det_active && det_hit &&
    ctrl1_reg[supply_guard_pkg::C1_DET_RST_EN] && !cmp_s_q.por_below
      |=> sys_rst_req && (cause_reg == supply_guard_pkg::CAUSE_UNDERVOLT)
  ) else $error("detect reset or its cause missing");

  AST_DET_HOLD: assert property (
    (state_reg == supply_guard_pkg::ST_DET_HOLD) && det_hit |=> sys_rst_req
  ) else $error("detect reset released below trip level");

  AST_IRQ_CAUSE: assert property (
    irq_req |-> (WARN_IRQ_VARIANT ?
      $past(warn_hit && ctrl1_reg[supply_guard_pkg::C1_WARN_IRQ_EN]) :
      $past(det_hit && !ctrl1_reg[supply_guard_pkg::C1_DET_RST_EN]))
  ) else $error("interrupt without its enabled cause");

  AST_WARN_IRQ_REPEAT: assert property (
    (WARN_IRQ_VARIANT &&
     (cmp_s_q.warn_below == $past(cmp_s_q.warn_below)) &&
     (state_reg == supply_guard_pkg::ST_RUN) && warn_hit &&
     !cmp_s_q.por_below && !det_hit &&
     ctrl1_reg[supply_guard_pkg::C1_WARN_IRQ_EN])[*3]
      |=> irq_req
  ) else $error("warning interrupt not kept up");

  AST_ACK_CLEARS_FLAG: assert property (
    (state_reg == supply_guard_pkg::ST_RUN) && wr_stb && !warn_hit &&
    (addr == supply_guard_pkg::OFS_PWR_CTRL_1) &&
    wr_data[supply_guard_pkg::C1_WARN_ACK]
      |=> !warn_flag_reg
  ) else $error("acknowledge did not clear warning flag");

  AST_FLAG_SET: assert property (
    (state_reg == supply_guard_pkg::ST_RUN) && warn_hit |=> warn_flag_reg
  ) else $error("warning flag not set at warning level");

  AST_DET_OFF_NO_RESET: assert property (
    (state_reg == supply_guard_pkg::ST_RUN) && !cmp_s_q.por_below &&
    !ctrl1_reg[supply_guard_pkg::C1_DET_EN] |=> !sys_rst_req
  ) else $error("detect reset taken with detection disabled");

  AST_WARN_LEVEL_IRQ: assert property (
    WARN_IRQ_VARIANT && (state_reg == supply_guard_pkg::ST_RUN) &&
    !cmp_s_q.por_below && !det_hit &&
    ctrl1_reg[supply_guard_pkg::C1_WARN_IRQ_EN] &&
    cmp_s_q.warn_below[{ctrl2_reg[supply_guard_pkg::C2_DET_LVL_SEL],
                        ctrl2_reg[supply_guard_pkg::C2_WARN_LVL_SEL]}]
      |=> irq_req
  ) else $error("warning interrupt missing at selected level");

  AST_FLAG_OWN_SELECT: assert property (
    !WARN_IRQ_VARIANT && (state_reg == supply_guard_pkg::ST_RUN) &&
    cmp_s_q.det_below[ctrl2_reg[supply_guard_pkg::C2_WARN_LVL_SEL]]
      |=> warn_flag_reg
  ) else $error("flag-only warning level not taken from its own select");

  AST_DET_IRQ: assert property (
    !WARN_IRQ_VARIANT && (state_reg == supply_guard_pkg::ST_RUN) &&
    !cmp_s_q.por_below && det_active && det_hit &&
    ctrl1_reg[supply_guard_pkg::C1_DET_IRQ_EN] &&
    !ctrl1_reg[supply_guard_pkg::C1_DET_RST_EN] |=> irq_req
  ) else $error("detect interrupt missing with both enables set");

  AST_ACK_READS_ZERO: assert property (
    rd_stb && (addr == supply_guard_pkg::OFS_PWR_CTRL_1)
      |=> !rd_data[supply_guard_pkg::C1_WARN_ACK]
  ) else $error("acknowledge bit did not read as zero");

  AST_SYNC_DELAY: assert property (
    $changed(cmp_raw.por_below) |-> ##2
      (cmp_s_q.por_below == $past(cmp_raw.por_below, 2))
  ) else $error("comparator not two cycles through synchroniser");

endmodule : supply_guard

// ==== supply_guard_pkg.sv ====
// shared constants and types for the supply-voltage supervisor control
package supply_guard_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_PWR_CTRL_1  = 8'h00;
  localparam logic [7:0] OFS_PWR_CTRL_2  = 8'h01;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h02;

  // power_mgmt_ctrl_1 field positions
  localparam int unsigned C1_WARN_FLAG   = 7;
  localparam int unsigned C1_WARN_ACK    = 6;
  localparam int unsigned C1_WARN_IRQ_EN = 5;
  localparam int unsigned C1_DET_RST_EN  = 4;
  localparam int unsigned C1_DET_STOP_EN = 3;
  localparam int unsigned C1_DET_EN      = 2;
  localparam int unsigned C1_DET_IRQ_EN  = 1;
  localparam int unsigned C1_BGAP_BUF_EN = 0;

  // power_mgmt_ctrl_2 field positions
  localparam int unsigned C2_DET_LVL_SEL  = 5;
  localparam int unsigned C2_WARN_LVL_SEL = 4;
  localparam int unsigned C2_PPD_FLAG     = 3;
  localparam int unsigned C2_PPD_CTRL     = 0;

  // reset_cause_status field positions
  localparam int unsigned RC_POWER_ON    = 7;
  localparam int unsigned RC_UNDERVOLT   = 1;

  // reset values and write masks
  localparam logic [7:0] PWR_CTRL_1_RST  = 8'h14;
  localparam logic [7:0] PWR_CTRL_1_WMSK = 8'h3f;
  localparam logic [7:0] PWR_CTRL_2_RST  = 8'h00;
  localparam logic [7:0] PWR_CTRL_2_WMSK = 8'h31;
  localparam logic [7:0] CAUSE_POWER_ON  = 8'h82;
  localparam logic [7:0] CAUSE_UNDERVOLT = 8'h02;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // detect comparator indices
  localparam int unsigned DET_LOW  = 0;
  localparam int unsigned DET_HIGH = 1;

  // comparator outputs, high while the supply sits below the level
  typedef struct packed {
    logic       por_below;
    logic [1:0] det_below;
    logic [3:0] warn_below;
  } cmp_s;

  localparam int unsigned CMP_W = $bits(cmp_s);

  // supervisor states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_POR_HOLD,
    ST_DET_HOLD
  } sup_state_e;

endpackage : supply_guard_pkg

// ==== cmp_sync.sv ====
// two-stage synchroniser for the comparator outputs
`timescale 1ns/1ps
module cmp_sync (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst_b,
  // raw and synchronised comparators
  input  wire supply_guard_pkg::cmp_s            cmp_raw,
  output      supply_guard_pkg::cmp_s            cmp_sync_out
);

  supply_guard_pkg::cmp_s meta_reg;
  supply_guard_pkg::cmp_s sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // reset to below every level, so no healthy supply is reported
      // before the first real samples have passed both stages
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= cmp_raw;
      sync_reg <= meta_reg;
    end
  end

  assign cmp_sync_out = sync_reg;

endmodule : cmp_sync

// ==== trip_select.sv ====
// picks the active detect and warning trip comparators
`timescale 1ns/1ps
module trip_select #(
  parameter bit WARN_IRQ_VARIANT = 1'b1
) (
  // synchronised comparators and level selects
  input  wire supply_guard_pkg::cmp_s cmp_in,
  input  wire logic                   det_lvl_sel,
  input  wire logic                   warn_lvl_sel,
  // selected trip conditions
  output      logic                   det_hit,
  output      logic                   warn_hit
);

  // one comparator out of a group, indexed by the select bits
  function automatic logic level_pick(input logic [3:0] lv,
                                      input logic [1:0] idx);
    level_pick = lv[idx];
  endfunction : level_pick

  // detect level from detect_level_select alone
  always_comb begin
    det_hit = level_pick({2'h0, cmp_in.det_below}, {1'b0, det_lvl_sel});
    if (WARN_IRQ_VARIANT) begin
      warn_hit = level_pick(cmp_in.warn_below,
                            {det_lvl_sel, warn_lvl_sel});
    end else begin
      // warning levels equal the detect levels here
      warn_hit = level_pick({2'h0, cmp_in.det_below},
                            {1'b0, warn_lvl_sel});
    end
  end

endmodule : trip_select

// ==== core_model.sv ====
// processor core stand-in: takes reset and interrupt, drives stop state
`timescale 1ns/1ps
module core_model (
  // clock
  input  wire logic clk_sys,
  // requests from the supervisor
  input  wire logic sys_rst_req,
  input  wire logic irq_req,
  // stop request from the bench
  input  wire logic stop_cmd,
  // stop state and interrupt activity
  output      logic stop_mode,
  output      int   irq_cycles
);
  // a core held in reset cannot sit in stop, so stop drops at the next clock edge
  always_ff @(posedge clk_sys) begin
    stop_mode <= stop_cmd & ~sys_rst_req;
  end
  // count cycles with the interrupt line asserted
  always @(posedge clk_sys) begin
    irq_cycles <= irq_cycles + (irq_req === 1'b1 ? 1 : 0);
  end
  initial irq_cycles = 0;
endmodule : core_model

// ==== supply_guard_bench.sv ====
// self-checking bench for the supply-voltage supervisor control
`timescale 1ns/1ps
module supply_guard_bench;
  logic                   clk_sys = 1'b0;
  logic                   rst_b = 1'b0;
  supply_guard_pkg::cmp_s cmp_raw = '0;
  logic                   stop_mode;
  logic                   stop_cmd = 1'b0;
  logic [7:0]             addr = 8'h00;
  logic [7:0]             wr_data = 8'h00;
  logic                   wr_stb = 1'b0;
  logic                   rd_stb = 1'b0;
  logic [7:0]             rd_data;
  logic                   sys_rst_req;
  logic                   irq_req;
  int                     irq_cycles;
  int                     bad_count = 0;
  int                     checks = 0;
  int                     base;
  logic                   rd_pend = 1'b0;
  logic [7:0]             exp_q[$];
  logic [7:0]             r;
  logic [8:0]             f;
  logic [8:0]             expf_q[$];
  logic [7:0]             rd_data_f;
  logic                   sys_rst_req_f;
  logic                   irq_req_f;

  always #12.5 clk_sys = ~clk_sys;

  supply_guard DUT (.clk_sys(clk_sys), .rst_b(rst_b), .cmp_raw(cmp_raw),
    .stop_mode(stop_mode), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .sys_rst_req(sys_rst_req),
    .irq_req(irq_req));

  core_model core (.clk_sys(clk_sys), .sys_rst_req(sys_rst_req),
    .irq_req(irq_req), .stop_cmd(stop_cmd), .stop_mode(stop_mode),
    .irq_cycles(irq_cycles));

  // flag-only variant watches the same inputs
  supply_guard #(.WARN_IRQ_VARIANT(1'b0)) DUT_FLAG (.clk_sys(clk_sys),
    .rst_b(rst_b), .cmp_raw(cmp_raw), .stop_mode(stop_mode), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data_f), .sys_rst_req(sys_rst_req_f), .irq_req(irq_req_f));

  task cmp_byte(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp_byte

  task cmp_bit(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp_bit

  // read data stand only in the cycle after the strobe, so look there
  always @(negedge clk_sys) begin
    if (rd_pend) begin
      cmp_byte(exp_q.pop_front(), rd_data);
      f = expf_q.pop_front();
      if (f[8]) begin
        cmp_byte(f[7:0], rd_data_f);
      end
    end
    rd_pend = rd_stb;
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clk_sys);
    wr_stb  <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp,
          input logic [8:0] expf = 9'h000);
    @(posedge clk_sys);
    exp_q.push_back(exp);
    expf_q.push_back(expf);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  task set_cmp(input logic p, input logic [1:0] d, input logic [3:0] w);
    @(posedge clk_sys);
    cmp_raw.por_below  <= p;
    cmp_raw.det_below  <= d;
    cmp_raw.warn_below <= w;
  endtask : set_cmp

  // settle past the synchroniser, then sample off the edge
  task settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // bounded wait for the reset request to reach a level
  task wait_rst(input logic lvl);
    for (int i = 0; i < 10 && sys_rst_req !== lvl; i++) begin
      @(negedge clk_sys);
    end
    cmp_bit(lvl, sys_rst_req);
    cmp_bit(lvl, sys_rst_req_f);
  endtask : wait_rst

  task test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // watchdog sized well above the expected few hundred cycles
  initial begin
    #500us;
    bad_count++;
    test_done();
  end

  initial begin
    void'($urandom(11896));
    repeat (16) @(posedge clk_sys);
    cmp_bit(1'b1, sys_rst_req);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    cmp_bit(1'b1, sys_rst_req);
    wait_rst(1'b0);
    rd(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h14);
    rd(supply_guard_pkg::OFS_PWR_CTRL_2, 8'h00);
    rd(supply_guard_pkg::OFS_RESET_CAUSE, 8'h82);
    rd(8'h05, 8'h00);
    wr(8'h05, 8'hff);
    r = 8'($urandom());
    wr(supply_guard_pkg::OFS_PWR_CTRL_1, r);
    rd(supply_guard_pkg::OFS_PWR_CTRL_1, r & 8'h3f);
    r = 8'($urandom());
    wr(supply_guard_pkg::OFS_PWR_CTRL_2, r);
    rd(supply_guard_pkg::OFS_PWR_CTRL_2, r & 8'h31);
    wr(supply_guard_pkg::OFS_RESET_CAUSE, 8'h00);
    rd(supply_guard_pkg::OFS_RESET_CAUSE, 8'h82);
    $display("test registers done");
    // warning interrupt over every level combination
    wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h24);
    for (int i = 0; i < 4; i++) begin
      wr(supply_guard_pkg::OFS_PWR_CTRL_2, {2'b00, 2'(i), 4'h0});
      set_cmp(1'b0, 2'b00, 4'(1 << ((i + 1) % 4)));
      settle(5);
      cmp_bit(1'b0, irq_req);
      set_cmp(1'b0, 2'b00, 4'(1 << i));
      settle(5);
      cmp_bit(1'b1, irq_req);
      base = irq_cycles;
      settle(8);
      cmp_byte(8'h08, 8'(irq_cycles - base));
      set_cmp(1'b0, 2'b00, 4'h0);
      settle(5);
      cmp_bit(1'b0, irq_req);
      wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h24);
      rd(supply_guard_pkg::OFS_PWR_CTRL_1, 8'ha4);
      wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h64);
      rd(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h24);
    end
    $display("test warning done");
    // detect level without reset enable: only the flag-only part interrupts
    wr(supply_guard_pkg::OFS_PWR_CTRL_2, 8'h20);
    wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h26);
    set_cmp(1'b0, 2'b11, 4'h0);
    settle(6);
    cmp_bit(1'b0, irq_req);
    cmp_bit(1'b1, irq_req_f);
    cmp_bit(1'b0, sys_rst_req);
    rd(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h26, {1'b1, 8'ha6});
    // detection off: no reset even with reset enable
    wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h12);
    settle(6);
    cmp_bit(1'b0, sys_rst_req);
    cmp_bit(1'b0, irq_req_f);
    set_cmp(1'b0, 2'b00, 4'h0);
    wr(supply_guard_pkg::OFS_PWR_CTRL_2, 8'h00);
    $display("test flag-only done");
    // stop without stop enable drops detection
    wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h14);
    stop_cmd <= 1'b1;
    set_cmp(1'b0, 2'b01, 4'h0);
    settle(6);
    cmp_bit(1'b0, sys_rst_req);
    set_cmp(1'b0, 2'b00, 4'h0);
    wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h1c);
    set_cmp(1'b0, 2'b01, 4'h0);
    settle(1);
    cmp_bit(1'b0, sys_rst_req);
    wait_rst(1'b1);
    @(posedge clk_sys);
    stop_cmd <= 1'b0;
    settle(8);
    cmp_bit(1'b1, sys_rst_req);
    set_cmp(1'b0, 2'b00, 4'h0);
    wait_rst(1'b0);
    rd(supply_guard_pkg::OFS_RESET_CAUSE, 8'h02);
    rd(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h14);
    $display("test detect low done");
    // high detect level selected, hold must stay at that level
    wr(supply_guard_pkg::OFS_PWR_CTRL_2, 8'h20);
    wr(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h16);
    set_cmp(1'b0, 2'b10, 4'h0);
    wait_rst(1'b1);
    cmp_bit(1'b0, irq_req_f);
    settle(8);
    cmp_bit(1'b1, sys_rst_req);
    set_cmp(1'b0, 2'b00, 4'h0);
    wait_rst(1'b0);
    rd(supply_guard_pkg::OFS_RESET_CAUSE, 8'h02);
    $display("test detect high done");
    // supply below power-on level mid-run
    set_cmp(1'b1, 2'b01, 4'h0);
    wait_rst(1'b1);
    set_cmp(1'b0, 2'b01, 4'h0);
    settle(8);
    cmp_bit(1'b1, sys_rst_req);
    set_cmp(1'b0, 2'b00, 4'h0);
    wait_rst(1'b0);
    rd(supply_guard_pkg::OFS_RESET_CAUSE, 8'h82);
    rd(supply_guard_pkg::OFS_PWR_CTRL_1, 8'h14);
    $display("test power-on done");
    test_done();
  end
endmodule : supply_guard_bench
